// [hw/usc_defines.svh]
`ifndef USC_DEFINES_SVH
`define USC_DEFINES_SVH
// register byte addresses: printed offsets are not all multiples of four,
// so each printed offset is an index and the byte address is four times it
`define USC_IDX_CTRL1 8'h05
`define USC_IDX_MASK 8'h06
`define USC_IDX_ADDR 8'h07
`define USC_IDX_PEND 8'h0d
`define USC_IDX_BUFSEL 8'h0e
`define USC_IDX_CTRL2 8'h0f
`define USC_IDX_FRM_LO 8'h15
`define USC_IDX_FRM_HI 8'h16
`define USC_IDX_CNT_LO 8'h35
`define USC_IDX_CNT_HI 8'h36
// control register 1 fields
`define USC_C1_USB_EN 0
`define USC_C1_DMA_EN 1
`define USC_C1_DMA_DIR 2
`define USC_C1_ENG_RST 3
`define USC_C1_FORCE 4
`define USC_C1_SPSEL 5
`define USC_C1_STBY 6
// event bit positions
`define USC_EV_DMA_BUSY 7
`define USC_EV_BUS_RST 6
`define USC_EV_SOF 5
`define USC_EV_DMA_DONE 4
// control register 2 fields
`define USC_C2_MASTER 7
`define USC_C2_SWAP 6
// reset values
`define USC_RST_BYTE 8'h00
`define USC_RST_COUNT 16'h0000
`endif

// [hw/usc_pkg.sv]
package usc_pkg;
  // events reported by the serial engine, one cycle pulses
  typedef struct packed {
    logic bus_reset;
    logic sof;
    logic [3:0] ep_done;
    logic [10:0] frame;
  } usc_events_t;
  // line drive towards the transceiver
  typedef struct packed {
    logic force_en;
    logic dp;
    logic dm;
  } usc_line_t;
  typedef enum logic [1:0] {
    USC_LINE_NORMAL = 2'b00,
    USC_LINE_SE0 = 2'b01,
    USC_LINE_K = 2'b10,
    USC_LINE_J = 2'b11
  } usc_force_t;
  typedef enum logic [1:0] {
    USC_BUS_IDLE = 2'b00,
    USC_BUS_WAIT = 2'b01
  } usc_bus_t;
endpackage : usc_pkg

// [hw/usc_ctrl_regs.sv]
// Our own choice: register access over AHB-Lite.
`timescale 1ns/100ps
`include "usc_defines.svh"
// Functional notes
// - line force pair selects normal, SE0, K or J drive on the data lines.
// - mask bit one lets its event drive the interrupt output.
// - mask changes never alter pending events; mask only gates the output.
// - mask bits: 6 bus reset, 5 SOF, 4 DMA done, 3..0 endpoints.
// - bit 7 of mask and pending reads DMA busy, never interrupts.
// - device address register resets to 00h and holds host value.
// - once addressed, only tokens matching the address are answered.
// - pending register reads flags; writing one clears, zero keeps.
// - pending bits: 6 bus reset, 5 SOF, 4 DMA done, 3..0 endpoints.
// - buffer select bit n shows endpoint n set a/b; 7..4 reserved.
// - control 2 bit 7 selects host (1) or slave (0).
// - control 2 bit 6 swaps data line polarity when one.
// - frame low holds 7 frame bits in 7:1, updated per SOF.
// - frame high holds 4 frame bits in 7:4, updated per SOF.
// - DMA count is 16 bits split over low and high registers.
// - writing count high starts DMA when DMA enable is set.
// - endpoint three moves data only by DMA.
// - interrupt request output is active high.
// - DMA enable permits DMA; start occurs only on count high write.
module usc_ctrl_regs
  import usc_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // ahb-lite slave
  input wire logic HSEL_I,
  input wire logic [ADDR_W-1:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // serial engine side
  input wire usc_events_t EVENTS_I,
  input wire logic [3:0] BUF_SET_I,
  input wire logic DMA_DONE_I,
  input wire logic [6:0] TOKEN_ADDR_I,
  input wire logic TOKEN_VALID_I,
  output logic TOKEN_MATCH_O,
  output logic EP3_DMA_ONLY_O,
  output logic USB_ENABLE_O,
  output logic STANDBY_O,
  output logic LOW_SPEED_O,
  output logic DMA_READ_O,
  output logic DMA_START_O,
  output logic [15:0] DMA_COUNT_O,
  output logic DMA_BUSY_O,
  output logic HOST_MODE_O,
  output logic POLARITY_SWAP_O,
  output usc_line_t LINE_O,
  output logic INTERRUPT_REQUEST_OUT_O
);

  logic [7:0] ctrl1;
  logic [7:0] interrupt_mask;
  logic [7:0] device_address;
  logic [6:0] pending_events;
  logic [1:0] role_polarity_control;
  logic [6:0] frame_number_low;
  logic [3:0] frame_number_high;
  logic [7:0] dma_count_low;
  logic [7:0] dma_count_high;
  logic dma_busy;
  logic dma_start;
  usc_bus_t bus_state;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] rd_byte;

  // word index from a byte address; non-word-aligned bits must be zero
  function automatic logic idx_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    idx_hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction : idx_hit

  // address phase qualification
  wire addr_valid = HSEL_I && HREADY_I && HTRANS_I[1];
  wire wr_phase = (bus_state == USC_BUS_WAIT);
  wire [7:0] wbyte = HWDATA_I[7:0];

  // write decode of the registered address, data phase
  wire wr_ctrl1 = wr_phase && idx_hit(wr_addr, `USC_IDX_CTRL1);
  wire wr_mask = wr_phase && idx_hit(wr_addr, `USC_IDX_MASK);
  wire wr_addr_reg = wr_phase && idx_hit(wr_addr, `USC_IDX_ADDR);
  wire wr_pend = wr_phase && idx_hit(wr_addr, `USC_IDX_PEND);
  wire wr_ctrl2 = wr_phase && idx_hit(wr_addr, `USC_IDX_CTRL2);
  wire wr_cnt_lo = wr_phase && idx_hit(wr_addr, `USC_IDX_CNT_LO);
  wire wr_cnt_hi = wr_phase && idx_hit(wr_addr, `USC_IDX_CNT_HI);

  // bus state: idle, or holding a write for its data phase
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      bus_state <= USC_BUS_IDLE;
      wr_addr <= '0;
    end else begin
      case (bus_state)
        USC_BUS_IDLE: begin
          if (addr_valid && HWRITE_I) begin
            bus_state <= USC_BUS_WAIT;
            wr_addr <= HADDR_I;
          end
        end
        default: begin
          if (addr_valid && HWRITE_I) begin
            wr_addr <= HADDR_I;
          end else begin
            bus_state <= USC_BUS_IDLE;
          end
        end
      endcase
    end
  end

  // zero wait states and always okay; unmapped reads return zero
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;

  // read mux, reserved and undefined bits read zero
  always_comb begin
    if (idx_hit(HADDR_I, `USC_IDX_CTRL1)) begin
      rd_byte = ctrl1;
    end else if (idx_hit(HADDR_I, `USC_IDX_MASK)) begin
      rd_byte = {dma_busy, interrupt_mask[6:0]};
    end else if (idx_hit(HADDR_I, `USC_IDX_ADDR)) begin
      rd_byte = device_address;
    end else if (idx_hit(HADDR_I, `USC_IDX_PEND)) begin
      rd_byte = {dma_busy, pending_events};
    end else if (idx_hit(HADDR_I, `USC_IDX_BUFSEL)) begin
      rd_byte = {4'h0, BUF_SET_I};
    end else if (idx_hit(HADDR_I, `USC_IDX_CTRL2)) begin
      rd_byte = {role_polarity_control, 6'h00};
    end else if (idx_hit(HADDR_I, `USC_IDX_FRM_LO)) begin
      rd_byte = {frame_number_low, 1'b0};
    end else if (idx_hit(HADDR_I, `USC_IDX_FRM_HI)) begin
      rd_byte = {frame_number_high, 4'h0};
    end else if (idx_hit(HADDR_I, `USC_IDX_CNT_LO)) begin
      rd_byte = dma_count_low;
    end else if (idx_hit(HADDR_I, `USC_IDX_CNT_HI)) begin
      rd_byte = dma_count_high;
    end else begin
      rd_byte = 8'h00;
    end
  end

  // read data captured at the address phase, stands during data phase
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      HRDATA_O <= 32'h0000_0000;
    end else if (addr_valid && !HWRITE_I) begin
      HRDATA_O <= {24'h00_0000, rd_byte};
    end
  end

  // plain control registers; bit 7 of ctrl1 is kept zero
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl1 <= `USC_RST_BYTE;
      interrupt_mask <= `USC_RST_BYTE;
      device_address <= `USC_RST_BYTE;
      role_polarity_control <= 2'b00;
      dma_count_low <= `USC_RST_BYTE;
      dma_count_high <= `USC_RST_BYTE;
    end else begin
      if (wr_ctrl1) ctrl1 <= {1'b0, wbyte[6:0]};
      if (wr_mask) interrupt_mask <= {1'b0, wbyte[6:0]};
      if (wr_addr_reg) device_address <= wbyte;
      if (wr_ctrl2) role_polarity_control <= wbyte[7:6];
      if (wr_cnt_lo) dma_count_low <= wbyte;
      if (wr_cnt_hi) dma_count_high <= wbyte;
    end
  end

  // start pulse only from a count-high write with enable set
  assign dma_start = wr_cnt_hi && ctrl1[`USC_C1_DMA_EN];

  // busy from start until the dma engine reports done or dma enable clears; start wins
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dma_busy <= 1'b0;
      DMA_START_O <= 1'b0;
    end else begin
      DMA_START_O <= dma_start;
      if (dma_start) dma_busy <= 1'b1;
      else if (DMA_DONE_I || !ctrl1[`USC_C1_DMA_EN]) dma_busy <= 1'b0;
    end
  end

  // sticky events; a set in the clearing cycle wins
  wire [6:0] ev_set = {EVENTS_I.bus_reset, EVENTS_I.sof, DMA_DONE_I && dma_busy, EVENTS_I.ep_done};
  wire [6:0] ev_clr = wr_pend ? wbyte[6:0] : 7'h00;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pending_events <= 7'h00;
    end else begin
      pending_events <= (pending_events & ~ev_clr) | ev_set;
    end
  end

  // frame number capture on each sof
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      frame_number_low <= 7'h00;
      frame_number_high <= 4'h0;
    end else if (EVENTS_I.sof) begin
      frame_number_low <= EVENTS_I.frame[6:0];
      frame_number_high <= EVENTS_I.frame[10:7];
    end
  end

  // bit 7 busy is excluded so it never interrupts
  assign INTERRUPT_REQUEST_OUT_O = |(pending_events & interrupt_mask[6:0]);

  // line forcing; usb engine reset is the low bit of the pair
  wire [1:0] force_pair = {ctrl1[`USC_C1_FORCE], ctrl1[`USC_C1_ENG_RST]};
  always_comb begin
    case (usc_force_t'(force_pair))
      USC_LINE_SE0: LINE_O = '{force_en: 1'b1, dp: 1'b0, dm: 1'b0};
      USC_LINE_K: LINE_O = '{force_en: 1'b1, dp: 1'b0, dm: 1'b1};
      USC_LINE_J: LINE_O = '{force_en: 1'b1, dp: 1'b1, dm: 1'b0};
      default: LINE_O = '{force_en: 1'b0, dp: 1'b0, dm: 1'b0};
    endcase
  end

  // address 0 is the default address before assignment, so it matches naturally
  assign TOKEN_MATCH_O = TOKEN_VALID_I && (TOKEN_ADDR_I == device_address[6:0]);
  assign EP3_DMA_ONLY_O = 1'b1;
  assign USB_ENABLE_O = ctrl1[`USC_C1_USB_EN];
  assign STANDBY_O = ctrl1[`USC_C1_STBY];
  assign LOW_SPEED_O = ctrl1[`USC_C1_SPSEL];
  assign DMA_READ_O = ctrl1[`USC_C1_DMA_DIR];
  assign DMA_COUNT_O = {dma_count_high, dma_count_low};
  assign DMA_BUSY_O = dma_busy;
  assign HOST_MODE_O = role_polarity_control[1];
  assign POLARITY_SWAP_O = role_polarity_control[0];

  sequence s_cnt_hi_en;
    wr_cnt_hi && ctrl1[`USC_C1_DMA_EN];
  endsequence
  sequence s_started;
    DMA_START_O && dma_busy;
  endsequence

  AST_DMA_START: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_cnt_hi_en |=> s_started) else $error("dma did not start on count high write");
  AST_NO_SPURIOUS_START: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    DMA_START_O |-> $past(wr_cnt_hi) && $past(ctrl1[`USC_C1_DMA_EN])) else $error("dma start without cause");
  AST_IRQ_GATE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    INTERRUPT_REQUEST_OUT_O == |(pending_events & interrupt_mask[6:0])) else $error("irq gating wrong");
  AST_MASK_KEEPS_PEND: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    wr_mask && !wr_pend && ev_set == 7'h00 |=> pending_events == $past(pending_events))
    else $error("mask write changed pending");
  AST_W1C: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    wr_pend && wbyte[`USC_EV_SOF] && !EVENTS_I.sof |=> !pending_events[`USC_EV_SOF]) else $error("w1c failed");
  AST_SET_WINS: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    EVENTS_I.bus_reset |=> pending_events[`USC_EV_BUS_RST]) else $error("bus reset event lost");
  AST_FRAME: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    EVENTS_I.sof |=> {frame_number_high, frame_number_low} == $past(EVENTS_I.frame)) else $error("frame capture");
  AST_SE0: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    force_pair == 2'b01 |-> LINE_O.force_en && !LINE_O.dp && !LINE_O.dm) else $error("se0 drive wrong");
  AST_ADDR_MATCH: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    TOKEN_MATCH_O |-> TOKEN_ADDR_I == device_address[6:0]) else $error("token match wrong");
  AST_BUSY_NO_IRQ: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    pending_events == 7'h00 |-> !INTERRUPT_REQUEST_OUT_O) else $error("busy raised irq");

  // read address phases of the status registers, data shows one cycle later
  sequence s_rd_mask;
    addr_valid && !HWRITE_I && idx_hit(HADDR_I, `USC_IDX_MASK);
  endsequence
  sequence s_rd_pend;
    addr_valid && !HWRITE_I && idx_hit(HADDR_I, `USC_IDX_PEND);
  endsequence
  sequence s_rd_bufsel;
    addr_valid && !HWRITE_I && idx_hit(HADDR_I, `USC_IDX_BUFSEL);
  endsequence
  sequence s_rd_ctrl2;
    addr_valid && !HWRITE_I && idx_hit(HADDR_I, `USC_IDX_CTRL2);
  endsequence

  // remaining line force codes
  AST_K_STATE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    force_pair == 2'b10 |-> LINE_O.force_en && !LINE_O.dp && LINE_O.dm)
    else $error("k drive wrong");
  AST_J_STATE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    force_pair == 2'b11 |-> LINE_O.force_en && LINE_O.dp && !LINE_O.dm)
    else $error("j drive wrong");
  // normal mode must release the lines to the engine
  AST_NORMAL_LINE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    force_pair == 2'b00 |-> !LINE_O.force_en)
    else $error("line forced in normal mode");

  // status reads, busy bit taken from the address phase
  AST_BUSY_READ: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_rd_mask |=> HRDATA_O[7] == $past(dma_busy))
    else $error("mask read busy bit wrong");
  AST_PEND_READ: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_rd_pend |=> HRDATA_O[7:0] == $past({dma_busy, pending_events}))
    else $error("pending read wrong");
  AST_BUFSEL_READ: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_rd_bufsel |=> HRDATA_O[7:0] == {4'h0, $past(BUF_SET_I)})
    else $error("buffer select read wrong");
  // reserved control 2 bits never leak onto the bus
  AST_CTRL2_RSVD: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_rd_ctrl2 |=> HRDATA_O[5:0] == 6'h00)
    else $error("reserved bits not zero");

  // register writes land at the end of the data phase
  AST_ADDR_WRITE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    wr_addr_reg |=> device_address == $past(wbyte))
    else $error("address write lost");
  AST_MASK_WRITE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    wr_mask |=> interrupt_mask[6:0] == $past(wbyte[6:0]))
    else $error("mask write lost");
  AST_HOST_SEL: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    wr_ctrl2 |=> HOST_MODE_O == $past(wbyte[`USC_C2_MASTER]))
    else $error("role select wrong");
  AST_SWAP_SEL: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    wr_ctrl2 |=> POLARITY_SWAP_O == $past(wbyte[`USC_C2_SWAP]))
    else $error("polarity swap wrong");
  AST_CNT_LOAD: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    wr_cnt_lo |=> DMA_COUNT_O[7:0] == $past(wbyte))
    else $error("count low write lost");

  // frame number only moves on a start of frame
  AST_FRM_HOLD: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !EVENTS_I.sof |=> $stable(frame_number_high) && $stable(frame_number_low))
    else $error("frame number moved without sof");

  // dma completion and enable handling
  AST_DONE_SET: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    DMA_DONE_I && dma_busy |=> pending_events[`USC_EV_DMA_DONE])
    else $error("dma done not flagged");
  AST_BUSY_OFF: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    dma_busy && !ctrl1[`USC_C1_DMA_EN] |=> !dma_busy)
    else $error("busy kept with dma disabled");

  // interrupt stays up until software clears or masks it
  AST_IRQ_HOLD: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    INTERRUPT_REQUEST_OUT_O && !wr_pend && !wr_mask |=> INTERRUPT_REQUEST_OUT_O)
    else $error("irq dropped without clear");

  // no match without a token, endpoint three tied to dma
  AST_NO_TOKEN: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !TOKEN_VALID_I |-> !TOKEN_MATCH_O)
    else $error("match without token");
  AST_EP3_DMA: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    EP3_DMA_ONLY_O)
    else $error("endpoint three not dma only");

endmodule : usc_ctrl_regs

// [tb/usc_engine_model.sv]
`timescale 1ns/100ps
module usc_engine_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic dma_start_i,
  input wire logic [7:0] delay_i,
  output logic dma_done_o,
  output int starts_o
);
  int left;
  // dma engine: finishes a started transfer delay_i cycles later
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left <= 0;
      dma_done_o <= 1'b0;
      starts_o <= 0;
    end else begin
      dma_done_o <= (left == 1);
      if (dma_start_i) begin
        starts_o <= starts_o + 1;
        left <= int'(delay_i);
      end else if (left > 0) begin
        left <= left - 1;
      end
    end
  end
endmodule : usc_engine_model

// [tb/usc_ctrl_regs_tb_top.sv]
`timescale 1ns/100ps
`include "usc_defines.svh"
module usc_ctrl_regs_tb_top;
  import usc_pkg::*;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, tok_v = 0;
  logic [9:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [31:0] hwdata = '0, hrdata, q;
  logic [3:0] bufset = '0;
  logic [6:0] tok = '0;
  logic hready, dstart, ddone, irq, tmatch, host, swap, busy, ep3;
  logic hresp, usben, stby, lspd, drd;
  logic [15:0] cnt;
  logic [10:0] fr;
  usc_events_t ev = '0;
  usc_line_t line;
  int error_cnt = 0, n_tests = 0, nstart, n0;
  logic [7:0] pend = '0, a, r, dly = 8'h14;
  usc_ctrl_regs u_dut (.CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .EVENTS_I(ev), .BUF_SET_I(bufset), .DMA_DONE_I(ddone),
    .TOKEN_ADDR_I(tok), .TOKEN_VALID_I(tok_v), .TOKEN_MATCH_O(tmatch), .EP3_DMA_ONLY_O(ep3),
    .USB_ENABLE_O(usben), .STANDBY_O(stby), .LOW_SPEED_O(lspd), .DMA_READ_O(drd), .DMA_START_O(dstart),
    .DMA_COUNT_O(cnt), .DMA_BUSY_O(busy), .HOST_MODE_O(host), .POLARITY_SWAP_O(swap), .LINE_O(line),
    .INTERRUPT_REQUEST_OUT_O(irq));
  usc_engine_model u_eng (.clk_i(clk), .rst_n_i(rst_n), .dma_start_i(dstart), .delay_i(dly),
    .dma_done_o(ddone), .starts_o(nstart));
  // free running bus clock
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one settled sample point after the edge
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  // single ahb-lite transfer, read data kept in q
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    haddr <= {idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    hsel <= 1'b1;
    do @(posedge clk); while (hready !== 1'b1 && ++n < 100);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1 && ++n < 100);
    q = hrdata;
    if (n >= 100) error_cnt++;
  endtask : xfer
  task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] exp, input logic [31:0] m = '1);
    xfer(1'b0, idx, '0);
    chk(nm, q & m, {24'h0, exp} & m);
  endtask : rdchk
  task automatic final_report;
    $display("errors %0d tests %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // hang guard, far above the expected run length
  initial begin
    #200000;
    error_cnt++;
    final_report();
  end
  initial begin
    void'($urandom(32'he8a07fa8));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    bufset <= 4'($urandom);
    step();
    rdchk("addr", `USC_IDX_ADDR, 8'h00);
    chk("hresp", hresp, 0);
    rdchk("bufsel", `USC_IDX_BUFSEL, {4'h0, bufset});
    chk("ep3", ep3, 1);
    a = 8'($urandom);
    xfer(1'b1, `USC_IDX_ADDR, {24'h0, a});
    rdchk("addr", `USC_IDX_ADDR, a);
    tok <= a[6:0];
    tok_v <= 1'b1;
    step();
    chk("match", tmatch, 1);
    tok <= ~a[6:0];
    step();
    chk("nomatch", tmatch, 0);
    // every line force code
    for (int f = 0; f < 4; f++) begin
      xfer(1'b1, `USC_IDX_CTRL1, f << 3);
      step();
      chk("line", line & (f != 0 ? 3'h7 : 3'h4), f == 1 ? 4 : f == 2 ? 5 : f == 3 ? 6 : 0);
    end
    xfer(1'b1, `USC_IDX_CTRL2, 32'hff);
    rdchk("ctrl2", `USC_IDX_CTRL2, 8'hc0);
    chk("role", {host, swap}, 2'b11);
    xfer(1'b1, `USC_IDX_CTRL2, 32'h40);
    step();
    chk("role", {host, swap}, 2'b01);
    // control 1 plain bits reach their pins; bit 7 is kept zero
    xfer(1'b1, `USC_IDX_CTRL1, 32'he7);
    rdchk("ctrl1", `USC_IDX_CTRL1, 8'h67);
    chk("ctrl1_pins", {usben, drd, lspd, stby}, 4'hf);
    // bus reset, SOF and all four endpoint events at once; mask still clear
    fr = 11'($urandom);
    @(posedge clk);
    ev <= '{1'b1, 1'b1, 4'hf, fr};
    @(posedge clk);
    ev <= '0;
    pend = 8'h6f;
    step();
    chk("irq", irq, 0);
    rdchk("frm_lo", `USC_IDX_FRM_LO, {fr[6:0], 1'b0}, 32'hfe);
    rdchk("frm_hi", `USC_IDX_FRM_HI, {fr[10:7], 4'h0}, 32'hf0);
    for (int i = 0; i < 7; i++) begin
      xfer(1'b1, `USC_IDX_MASK, 1 << i);
      rdchk("mask", `USC_IDX_MASK, 8'(1 << i));
      chk("irq", irq, pend[i]);
      rdchk("pend", `USC_IDX_PEND, pend);
    end
    xfer(1'b1, `USC_IDX_MASK, 32'h7f);
    repeat (3) begin
      r = 8'($urandom);
      xfer(1'b1, `USC_IDX_PEND, {24'h0, r});
      pend = pend & ~r;
      rdchk("w1c", `USC_IDX_PEND, pend);
      chk("irq", irq, |pend[6:0]);
    end
    xfer(1'b1, `USC_IDX_PEND, 32'hff);
    xfer(1'b1, `USC_IDX_MASK, 32'h80);
    // dma launched by count high, low written first
    xfer(1'b1, `USC_IDX_CTRL1, 32'h02);
    n0 = nstart;
    a = 8'($urandom);
    r = 8'($urandom);
    xfer(1'b1, `USC_IDX_CNT_LO, {24'h0, a});
    xfer(1'b1, `USC_IDX_CNT_HI, {24'h0, r});
    step();
    chk("count", cnt, {r, a});
    chk("starts", nstart, n0 + 1);
    rdchk("busy", `USC_IDX_MASK, 8'h80, 32'h80);
    chk("irq", irq, 0);
    n0 = 0;
    while (busy !== 1'b0 && n0 < 200) begin
      step();
      n0++;
    end
    step();
    rdchk("done", `USC_IDX_PEND, 8'h10);
    xfer(1'b1, `USC_IDX_MASK, 32'h10);
    step();
    chk("irq", irq, 1);
    xfer(1'b1, `USC_IDX_CTRL1, 32'h00);
    n0 = nstart;
    xfer(1'b1, `USC_IDX_CNT_LO, 32'h05);
    xfer(1'b1, `USC_IDX_CNT_HI, 32'h00);
    step();
    chk("nostart", nstart, n0);
    // mid-run reset returns the address and interrupt to idle
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk("addr_rst", `USC_IDX_ADDR, 8'h00);
    chk("irq_rst", irq, 0);
    final_report();
  end
endmodule : usc_ctrl_regs_tb_top
